// >>> sop_unit.sv
`timescale 1ns/10ps
module sop_unit
  import sop_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             irq_enable,
  output logic             wb_valid,
  output logic [5:0]       wb_dest,
  output logic [15:0]      wb_data
);

  sop_ahb_req_t dph_reg;
  sop_ahb_req_t dph_next;
  logic         rd_wait_reg;
  logic [15:0]  insn_reg;
  logic [15:0]  operand_reg;
  logic [15:0]  operand_next;
  logic [15:0]  result_reg;
  sop_flags_t   flags_reg;
  sop_flags_t   flags_next;
  logic         ie_arm_reg;
  logic [15:0]  status_reg;
  logic [31:0]  rd_word;
  sop_exec_t    ex;

  // Address phase is taken only while the bus is ready.
  wire logic addr_take = hsel & htrans[1] & hready;
  wire logic addr_hit  = (haddr[31:8] == 24'h000000);
  assign dph_next = '{addr: haddr[7:0], write: hwrite,
                      mapped: addr_hit, valid: addr_take};

  wire logic dph_wr   = dph_reg.valid & dph_reg.write & dph_reg.mapped;
  wire logic wr_insn  = dph_wr & (dph_reg.addr == SOP_OFF_INSN);
  wire logic wr_oper  = dph_wr & (dph_reg.addr == SOP_OFF_OPERAND);
  wire logic wr_flags = dph_wr & (dph_reg.addr == SOP_OFF_FLAGS);
  wire logic rd_start = addr_take & ~hwrite;

  // Instruction fields, taken from the write data of an instruction store.
  wire logic [15:0] insn_w   = hwdata[15:0];
  wire logic        class_ok = insn_w[SOP_TAG_MSB:SOP_TAG_LSB]
                               == SOP_CLASS_TAG;
  wire sop_opc_t    opc      = sop_opc_t'(insn_w[SOP_OPC_MSB:SOP_OPC_LSB]);
  wire logic [2:0]  par      = insn_w[SOP_PAR_MSB:SOP_PAR_LSB];
  wire logic [5:0]  dst      = insn_w[SOP_DST_MSB:SOP_DST_LSB];
  wire logic [3:0]  cnt      = {1'b0, par} + 4'h1;

  // Datapath candidates on the destination value.
  wire logic [15:0] d        = operand_reg;
  wire logic [31:0] dd       = {d, d};
  wire logic [31:0] dd_rr    = dd >> cnt;
  wire logic [31:0] dd_rl    = dd << cnt;
  wire logic [15:0] v_shr    = $signed(d) >>> cnt;
  wire logic [15:0] v_shl    = d << cnt;
  wire logic [15:0] v_ror    = dd_rr[15:0];
  wire logic [15:0] v_rol    = dd_rl[31:16];
  wire logic [15:0] v_add    = d + {12'h000, cnt};
  wire logic [15:0] v_sub    = d - {12'h000, cnt};
  wire logic [15:0] v_inv    = ~d;
  wire logic [15:0] v_neg    = 16'h0000 - d;
  wire logic [15:0] v_sext   = {{8{d[7]}}, d[7:0]};
  // Last bit out of the LSB end is d[cnt-1], out of the MSB end d[16-cnt].
  wire logic        c_right  = d[par];
  wire logic        c_left   = d[{1'b1, ~par}];

  always_comb
  begin
    ex = '{value: d, flags: flags_reg, wb: 1'b0, illegal: 1'b0,
           ie_arm: 1'b0, ie_clr: 1'b0};
    if (!class_ok)
    begin
      ex.illegal = 1'b1;
    end
    else
    begin
      unique case (opc)
        SOP_OP_SHIFT_RIGHT_SIGNED:
        begin
          ex.value   = v_shr;
          ex.flags.c = c_right;
          ex.wb      = 1'b1;
        end
        SOP_OP_SHIFT_LEFT:
        begin
          ex.value   = v_shl;
          ex.flags.c = c_left;
          ex.wb      = 1'b1;
        end
        SOP_OP_ROTATE_RIGHT:
        begin
          ex.value   = v_ror;
          ex.flags.c = c_right;
          ex.wb      = 1'b1;
        end
        SOP_OP_ROTATE_LEFT:
        begin
          ex.value   = v_rol;
          ex.flags.c = c_left;
          ex.wb      = 1'b1;
        end
        SOP_OP_ADD_SMALL_IMM:
        begin
          ex.value = v_add;
          ex.wb    = 1'b1;
        end
        SOP_OP_SUB_SMALL_IMM:
        begin
          ex.value = v_sub;
          ex.wb    = 1'b1;
        end
        SOP_OP_EXTENDED:
        begin
          if (par == SOP_PAR_INVERT)
          begin
            ex.value = v_inv;
            ex.wb    = 1'b1;
          end
          else if (par == SOP_PAR_FLIP)
          begin
            ex.value   = v_neg;
            ex.flags.c = (d != 16'h0000);
            ex.flags.o = (d == 16'h8000);
            ex.wb      = 1'b1;
          end
          else if (par == SOP_PAR_SEXT)
          begin
            ex.value = v_sext;
            ex.wb    = 1'b1;
          end
          else if (par == SOP_PAR_MISC && dst == SOP_LOW_IE_SET)
          begin
            ex.ie_arm = 1'b1;
          end
          else if (par == SOP_PAR_MISC && dst == SOP_LOW_IE_CLR)
          begin
            ex.flags.i = 1'b0;
            ex.ie_clr  = 1'b1;
          end
          else if (par == SOP_PAR_MISC && dst == SOP_LOW_C_SET)
          begin
            ex.flags.c = 1'b1;
          end
          else if (par == SOP_PAR_MISC && dst == SOP_LOW_C_CLR)
          begin
            ex.flags.c = 1'b0;
          end
          else
          begin
            ex.illegal = 1'b1;
          end
        end
        default:
        begin
          ex.illegal = 1'b1;
        end
      endcase
    end
    // Every value-producing operation refreshes zero and sign.
    if (ex.wb)
    begin
      ex.flags.z = (ex.value == 16'h0000);
      ex.flags.s = ex.value[15];
    end
  end

  // A pending enable lands one cycle late unless a clear overtakes it.
  always_comb
  begin
    flags_next = flags_reg;
    if (wr_flags)
    begin
      flags_next = sop_flags_t'(hwdata[4:0]);
    end
    if (wr_insn)
    begin
      flags_next = ex.flags;
    end
    if (ie_arm_reg && !(wr_insn && ex.ie_clr))
    begin
      flags_next.i = 1'b1;
    end
  end

  assign operand_next = (wr_insn && ex.wb) ? ex.value :
                        wr_oper ? hwdata[15:0] : operand_reg;

  always_comb
  begin
    rd_word = 32'h00000000;
    if (dph_reg.mapped)
    begin
      unique case (dph_reg.addr)
        SOP_OFF_INSN:    rd_word = {16'h0000, insn_reg};
        SOP_OFF_OPERAND: rd_word = {16'h0000, operand_reg};
        SOP_OFF_RESULT:  rd_word = {16'h0000, result_reg};
        SOP_OFF_FLAGS:   rd_word = {27'h0, flags_reg};
        SOP_OFF_STATUS:  rd_word = {16'h0000, status_reg};
        default:         rd_word = 32'h00000000;
      endcase
    end
  end

  // Bus slave: writes finish at once, reads add one wait state.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_reg     <= '0;
      rd_wait_reg <= 1'b0;
      hreadyout   <= 1'b1;
      hrdata      <= 32'h00000000;
      hresp       <= 1'b0;
    end
    else
    begin
      if (hready)
      begin
        dph_reg <= dph_next;
      end
      rd_wait_reg <= rd_start;
      hreadyout   <= ~rd_start;
      if (rd_wait_reg)
      begin
        hrdata <= rd_word;
      end
    end
  end

  // Execution and write-back.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      insn_reg    <= SOP_WORD_RST;
      operand_reg <= SOP_WORD_RST;
      result_reg  <= SOP_WORD_RST;
      flags_reg   <= sop_flags_t'(SOP_FLAGS_RST);
      ie_arm_reg  <= 1'b0;
      status_reg  <= SOP_WORD_RST;
      irq_enable  <= 1'b0;
      wb_valid    <= 1'b0;
      wb_dest     <= 6'h00;
      wb_data     <= SOP_WORD_RST;
    end
    else
    begin
      operand_reg <= operand_next;
      flags_reg   <= flags_next;
      irq_enable  <= flags_next.i;
      ie_arm_reg  <= wr_insn & ex.ie_arm;
      wb_valid    <= wr_insn & ex.wb;
      if (wr_insn)
      begin
        insn_reg   <= insn_w;
        status_reg <= {2'b00, dst, 5'h00, ex.ie_arm, ex.wb, ex.illegal};
        if (ex.wb)
        begin
          result_reg <= ex.value;
          wb_dest    <= dst;
          wb_data    <= ex.value;
        end
      end
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  wire logic x_ok  = wr_insn & class_ok;
  wire logic x_ext = x_ok & (opc == SOP_OP_EXTENDED);
  wire logic x_sti = x_ext & (par == SOP_PAR_MISC) & (dst == SOP_LOW_IE_SET);
  wire logic x_cli = x_ext & (par == SOP_PAR_MISC) & (dst == SOP_LOW_IE_CLR);
  wire logic x_stc = x_ext & (par == SOP_PAR_MISC) & (dst == SOP_LOW_C_SET);

  class_reject_a: assert property (wr_insn && !class_ok
    |=> !wb_valid && status_reg[SOP_ST_ILLEGAL])
    else $error("foreign class word was executed");
  count_plus_a: assert property (x_ok && opc == SOP_OP_ADD_SMALL_IMM
    |=> wb_data == $past(operand_reg) + {12'h000, $past(par)} + 16'h0001)
    else $error("small add did not use field plus one");
  dest_pass_a: assert property (x_ok && opc <= SOP_OP_SUB_SMALL_IMM
    |=> wb_valid && wb_dest == $past(dst))
    else $error("write-back destination mismatch");
  shr_value_a: assert property (x_ok
    && opc == SOP_OP_SHIFT_RIGHT_SIGNED
    |=> wb_data[15] == $past(operand_reg[15])
        && flags_reg.c == $past(operand_reg[par]))
    else $error("signed right shift wrong");
  shl_carry_a: assert property (x_ok && opc == SOP_OP_SHIFT_LEFT
    |=> flags_reg.z == (wb_data == 16'h0000) && flags_reg.s == wb_data[15]
        && flags_reg.c == $past(operand_reg[4'hf - {1'b0, par}]))
    else $error("left shift flags wrong");
  ror_carry_a: assert property (x_ok && opc == SOP_OP_ROTATE_RIGHT
    |=> flags_reg.c == wb_data[15])
    else $error("rotate right carry is not the wrapped bit");
  rotl_carry_a: assert property (x_ok && opc == SOP_OP_ROTATE_LEFT
    |=> flags_reg.c == wb_data[0])
    else $error("rotate left carry is not the wrapped bit");
  sub_flags_a: assert property (x_ok && opc == SOP_OP_SUB_SMALL_IMM
    |=> $stable(flags_reg.c) && $stable(flags_reg.o))
    else $error("small subtract touched carry or overflow");
  flip_value_a: assert property (x_ext && par == SOP_PAR_FLIP
    |=> wb_data + $past(operand_reg) == 16'h0000
        && flags_reg.o == ($past(operand_reg) == 16'h8000))
    else $error("negation wrong");
  ie_delay_a: assert property (x_sti && !flags_reg.i
    |=> !irq_enable ##1 (irq_enable || $past(x_cli)))
    else $error("interrupt enable not one cycle late");
  ie_clear_a: assert property (x_cli
    |=> !irq_enable && $stable(flags_reg.c) && $stable(flags_reg.z))
    else $error("interrupt enable clear wrong");
  carry_set_a: assert property (x_stc
    |=> flags_reg.c && $stable(flags_reg.z) && $stable(flags_reg.s))
    else $error("carry set wrong");

  cover_rotate_c: cover property (x_ok && opc == SOP_OP_ROTATE_LEFT
                                  && par == 3'h7);
  cover_ie_c: cover property (x_sti ##2 irq_enable);
  cover_read_c: cover property (rd_start ##2 hreadyout);

endmodule

// >>> sop_pkg.sv
package sop_pkg;

  // Byte offsets of the register words on the bus.
  localparam logic [7:0]  SOP_OFF_INSN    = 8'h00;
  localparam logic [7:0]  SOP_OFF_OPERAND = 8'h04;
  localparam logic [7:0]  SOP_OFF_RESULT  = 8'h08;
  localparam logic [7:0]  SOP_OFF_FLAGS   = 8'h0c;
  localparam logic [7:0]  SOP_OFF_STATUS  = 8'h10;

  // Instruction word fields.
  localparam int          SOP_TAG_MSB     = 15;
  localparam int          SOP_TAG_LSB     = 12;
  localparam int          SOP_OPC_MSB     = 11;
  localparam int          SOP_OPC_LSB     = 9;
  localparam int          SOP_PAR_MSB     = 8;
  localparam int          SOP_PAR_LSB     = 6;
  localparam int          SOP_DST_MSB     = 5;
  localparam int          SOP_DST_LSB     = 0;
  localparam logic [3:0]  SOP_CLASS_TAG   = 4'hd;

  // Parameter field codes of the extended group.
  localparam logic [2:0]  SOP_PAR_INVERT  = 3'h0;
  localparam logic [2:0]  SOP_PAR_FLIP    = 3'h1;
  localparam logic [2:0]  SOP_PAR_SEXT    = 3'h2;
  localparam logic [2:0]  SOP_PAR_MISC    = 3'h7;

  // Low field codes of the flag group.
  localparam logic [5:0]  SOP_LOW_IE_SET  = 6'h00;
  localparam logic [5:0]  SOP_LOW_IE_CLR  = 6'h01;
  localparam logic [5:0]  SOP_LOW_C_SET   = 6'h02;
  localparam logic [5:0]  SOP_LOW_C_CLR   = 6'h03;

  // Status word fields.
  localparam int          SOP_ST_ILLEGAL  = 0;
  localparam int          SOP_ST_WB       = 1;
  localparam int          SOP_ST_IE_PEND  = 2;
  localparam int          SOP_ST_DST_LSB  = 8;

  // Reset values.
  localparam logic [15:0] SOP_WORD_RST    = 16'h0000;
  localparam logic [4:0]  SOP_FLAGS_RST   = 5'h00;

  typedef enum logic [2:0] {
    SOP_OP_SHIFT_RIGHT_SIGNED = 3'h0,
    SOP_OP_SHIFT_LEFT         = 3'h1,
    SOP_OP_ROTATE_RIGHT       = 3'h2,
    SOP_OP_ROTATE_LEFT        = 3'h3,
    SOP_OP_ADD_SMALL_IMM      = 3'h4,
    SOP_OP_SUB_SMALL_IMM      = 3'h5,
    SOP_OP_EXTENDED           = 3'h7
  } sop_opc_t;

  typedef struct packed {
    logic i;
    logic s;
    logic o;
    logic c;
    logic z;
  } sop_flags_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       mapped;
    logic       valid;
  } sop_ahb_req_t;

  typedef struct packed {
    logic [15:0] value;
    sop_flags_t  flags;
    logic        wb;
    logic        illegal;
    logic        ie_arm;
    logic        ie_clr;
  } sop_exec_t;

endpackage

// >>> sop_rf_model.sv
`timescale 1ns/10ps
module sop_rf_model
  import sop_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        wb_valid,
  input  wire logic [5:0]  wb_dest,
  input  wire logic [15:0] wb_data,
  output logic      [15:0] wb_count
);
  logic [15:0] rf [64];

  // The register file resolves the raw destination field and stores each
  // write-back there, counting pulses so the bench can spot double writes.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wb_count <= 16'h0000;
    else if (wb_valid)
    begin
      wb_count <= wb_count + 16'h0001;
      rf[wb_dest] <= wb_data;
    end
endmodule

// >>> tb.sv
`timescale 1ns/10ps
module tb
  import sop_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        irq_enable;
  logic        wb_valid;
  logic [5:0]  wb_dest;
  logic [15:0] wb_data;
  logic [15:0] wb_count;
  logic [31:0] g;
  logic [15:0] bad_words [4];
  logic [15:0] t_w;
  logic [15:0] t_v;
  logic [4:0]  t_f;
  int          fail_count;
  int          n_tests;
  int          cyc = 0;

  always #4 hclk = ~hclk;

  sop_unit i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .irq_enable(irq_enable),
    .wb_valid(wb_valid), .wb_dest(wb_dest), .wb_data(wb_data));

  sop_rf_model i_rf (.hclk(hclk), .hresetn(hresetn), .wb_valid(wb_valid),
    .wb_dest(wb_dest), .wb_data(wb_data), .wb_count(wb_count));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Both bus tasks start right after a rising edge and hold each phase
  // until hready is seen high at an edge.
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(a, 1'b0, 32'h00000000, q);
  endtask

  // Reference result: flags in bits 20:16, value in bits 15:0.
  function automatic logic [20:0] model(input logic [15:0] w,
                                        input logic [15:0] v,
                                        input logic [4:0]  f);
    logic [2:0]  op;
    logic [2:0]  p;
    logic [4:0]  n;
    logic [15:0] r;
    logic [4:0]  o;
    op = w[11:9];
    p = w[8:6];
    n = {2'b00, p} + 5'd1;
    o = f;
    case (op)
      3'h0: r = $signed(v) >>> n;
      3'h1: r = v << n;
      3'h2: r = (v >> n) | (v << (16 - n));
      3'h3: r = (v << n) | (v >> (16 - n));
      3'h4: r = v + {11'h000, n};
      3'h5: r = v - {11'h000, n};
      default: r = (p == 3'h0) ? ~v : (p == 3'h1) ? -v :
                   (p == 3'h2) ? {{8{v[7]}}, v[7:0]} : v;
    endcase
    if (op < 3'h4)
      o[1] = (op == 3'h0) ? v[n - 1] : (op == 3'h1) ? v[16 - n] :
             (op == 3'h2) ? r[15] : r[0];
    if (op == 3'h7 && p == 3'h1)
      o[2:1] = {v == 16'h8000, v != 16'h0000};
    if (op == 3'h7 && p == 3'h7)
      o = w[1] ? {f[4:2], ~w[0], f[0]} : {~w[0], f[3:0]};
    else
      o = {o[4], r[15], o[2:1], r == 16'h0000};
    return {o, r};
  endfunction

  task automatic run(input logic [15:0] w, input logic [15:0] v,
                     input logic [4:0] f);
    logic [20:0] e;
    logic [15:0] c;
    e = model(w, v, f);
    wr(SOP_OFF_OPERAND, {16'h0000, v});
    wr(SOP_OFF_FLAGS, {27'h0, f});
    c = wb_count;
    wr(SOP_OFF_INSN, {16'h0000, w});
    rd(SOP_OFF_OPERAND, g);
    check(g, {16'h0000, e[15:0]}, "value");
    rd(SOP_OFF_FLAGS, g);
    check(g, {27'h0, e[20:16]}, "flags");
    if (w[11:6] != 6'h3f)
    begin
      rd(SOP_OFF_RESULT, g);
      check(g, {16'h0000, e[15:0]}, "result");
      check({16'h0000, i_rf.rf[w[5:0]]}, {16'h0000, e[15:0]}, "rf");
      check({16'h0000, wb_count - c}, 32'h1, "pulses");
    end
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    fail_count = 0;
    n_tests = 0;
    bad_words = '{16'h1234, 16'hdc00, 16'hdec0, 16'hdfc4};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(SOP_OFF_FLAGS, g);
    check(g, 32'h0, "flags after reset");
    check({31'h0, irq_enable}, 32'h0, "irq after reset");
    $display("test reset done");
    for (int op = 0; op < 6; op++)
      for (int k = 0; k < 3; k++)
        for (int j = 0; j < 2; j++)
        begin
          t_w = {4'hd, op[2:0], k == 2 ? 3'h7 : 3'(3 * k), op[2:0], 3'(k)};
          t_v = j ? 16'h4c31 : 16'h8c32;
          t_f = j ? 5'h1f : 5'h04;
          run(t_w, t_v, t_f);
        end
    run({4'hd, 3'h4, 3'h7, 6'h11}, 16'hfff8, 5'h06);
    run({4'hd, 3'h5, 3'h0, 6'h12}, 16'h0000, 5'h01);
    $display("test shifts and immediates done");
    for (int p = 0; p < 3; p++)
      for (int j = 0; j < 3; j++)
      begin
        t_w = {4'hd, 3'h7, 3'(p), 6'(8 * p + j)};
        t_v = j == 0 ? 16'h8000 : j == 1 ? 16'h0000 : 16'h00f0;
        run(t_w, t_v, 5'h1a);
      end
    for (int l = 0; l < 4; l++)
    begin
      t_w = {4'hd, 3'h7, 3'h7, 6'(l)};
      t_f = l[0] ? 5'h1f : 5'h00;
      run(t_w, 16'h1234, t_f);
    end
    $display("test extended and flag ops done");
    wr(SOP_OFF_FLAGS, 32'h0);
    wr(SOP_OFF_INSN, {16'h0000, 4'hd, 3'h7, 3'h7, SOP_LOW_IE_SET});
    @(negedge hclk);
    check({31'h0, irq_enable}, 32'h0, "irq too early");
    @(negedge hclk);
    check({31'h0, irq_enable}, 32'h1, "irq late");
    @(posedge hclk);
    wr(SOP_OFF_INSN, {16'h0000, 4'hd, 3'h7, 3'h7, SOP_LOW_IE_CLR});
    @(negedge hclk);
    check({31'h0, irq_enable}, 32'h0, "irq not cleared");
    @(posedge hclk);
    $display("test enable timing done");
    for (int i = 0; i < 4; i++)
    begin
      wr(SOP_OFF_OPERAND, 32'h00005a5a);
      wr(SOP_OFF_FLAGS, 32'h0000000a);
      wr(SOP_OFF_INSN, {16'h0000, bad_words[i]});
      rd(SOP_OFF_STATUS, g);
      check({31'h0, g[SOP_ST_ILLEGAL]}, 32'h1, "illegal flag");
      rd(SOP_OFF_FLAGS, g);
      check(g, 32'h0000000a, "illegal flags");
      rd(SOP_OFF_OPERAND, g);
      check(g, 32'h00005a5a, "illegal value");
    end
    wr(8'h40, 32'hffffffff);
    rd(8'h40, g);
    check(g, 32'h0, "unmapped read");
    rd(SOP_OFF_FLAGS, g);
    check(g, 32'h0000000a, "unmapped write");
    check({31'h0, hresp}, 32'h0, "okay response");
    $display("test refusals done");
    complete_run();
  end
endmodule
